// >>> pkg/lts_pkg.sv
package lts_pkg;
	localparam int AXI_AW = 8;
	localparam int CNT_W = 16;
	localparam int CTRL_W = 5;

	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_CMD = 8'h04;
	localparam logic [AXI_AW-1:0] REG_SRC = 8'h08;
	localparam logic [AXI_AW-1:0] REG_ARM_CNT = 8'h0c;
	localparam logic [AXI_AW-1:0] REG_SCAN_CNT = 8'h10;
	localparam logic [AXI_AW-1:0] REG_MEAS_CNT = 8'h14;
	localparam logic [AXI_AW-1:0] REG_TIMER = 8'h18;
	localparam logic [AXI_AW-1:0] REG_SETTLE = 8'h1c;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h20;

	localparam int CTRL_ADV = 0;
	localparam int CTRL_CONT = 1;
	localparam int CTRL_SCAN = 2;
	localparam int CTRL_INT = 3;
	localparam int CTRL_FUNC = 4;
	localparam int CMD_INIT = 0;
	localparam int CMD_TRG = 1;
	localparam int CMD_ABORT = 2;
	localparam int SRC_ARM_LSB = 0;
	localparam int SRC_SCAN_LSB = 4;
	localparam int SRC_FRONT_PANEL_FIRE_KEY_LSB = 8;

	typedef logic [2:0] lts_src_t;
	localparam lts_src_t SRC_IMM = 3'h0;
	localparam lts_src_t SRC_EXT = 3'h1;
	localparam lts_src_t SRC_MAN = 3'h2;
	localparam lts_src_t SRC_BUS = 3'h3;
	localparam lts_src_t SRC_LINK = 3'h4;
	localparam lts_src_t SRC_TIMER = 3'h5;
	localparam lts_src_t SRC_HOLD = 3'h6;

	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h01;
	localparam logic [CNT_W-1:0] CNT_INFINITE = 16'h0000;
	localparam logic [CNT_W-1:0] ARM_CNT_RST = 16'h0001;
	localparam logic [CNT_W-1:0] SCAN_CNT_RST = 16'h0001;
	localparam logic [CNT_W-1:0] TIMER_RST = 16'h000a;
	localparam logic [CNT_W-1:0] SETTLE_RST = 16'h0064;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_US = 100;
	localparam int TICK_CYC = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int OUT_PULSE_NS = 10000;
	localparam int OUT_CYC = (OUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ARM, ST_SCAN, ST_FRONT_PANEL_FIRE_KEY, ST_FUNC,
		ST_OPEN, ST_CLOSE, ST_SETTLE, ST_MEAS, ST_OUT
	} lts_state_t;
endpackage : lts_pkg

// >>> verilog/lts_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lts_pin_sync #(
	parameter int W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] prev;
		logic [W-1:0] rise;
	} lts_sync_t;

	lts_sync_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.s1 = pin;
		s_d.s2 = s_q.s1;
		s_d.prev = s_q.s2;
		s_d.rise = s_q.s2 & ~s_q.prev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rise = s_q.rise;
endmodule : lts_pin_sync
`default_nettype wire

// >>> verilog/lts_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lts_interval_timer import lts_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic restart,
	input wire logic consume,
	input wire logic [CNT_W-1:0] interval,
	output logic due
);
	typedef struct packed {
		logic first;
		logic [CNT_W-1:0] cnt;
	} lts_tmr_t;

	lts_tmr_t s_q, s_d;

	// first pass after layer entry is free; later passes wait the interval
	always_comb begin
		s_d = s_q;
		if (restart) begin
			s_d.first = 1'b1;
			s_d.cnt = '0;
		end else if (consume) begin
			s_d.first = 1'b0;
			s_d.cnt = '0;
		end else if (tick && s_q.cnt < interval) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '{first: 1'b1, cnt: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign due = s_q.first || (s_q.cnt >= interval);
endmodule : lts_interval_timer
`default_nettype wire

// >>> verilog/lts_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module lts_sequencer import lts_pkg::*; #(
	parameter int CHAN_COUNT = 10,
	parameter int CHAN_W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_trigger_input,
	input wire logic daisy_chain_trigger_source,
	input wire logic front_panel_fire_key,
	input wire logic bus_group_trigger,
	input wire logic meas_done,
	output logic seq_active,
	output logic meas_start,
	output logic func_change,
	output logic relay_open,
	output logic relay_close,
	output logic [CHAN_W-1:0] relay_channel,
	output logic output_trigger
);
	localparam int TICK_W = $clog2(TICK_CYC);

	typedef struct packed {
		lts_state_t st;
		logic [CNT_W-1:0] arm_cnt;
		logic [CNT_W-1:0] scan_cnt;
		logic [CNT_W-1:0] meas_cnt;
		logic [CNT_W-1:0] dly;
		logic [CHAN_W-1:0] chan;
		logic [CTRL_W-1:0] ctrl;
		lts_src_t src_arm;
		lts_src_t src_scan;
		lts_src_t src_front_panel_fire_key;
		logic [CNT_W-1:0] lim_arm;
		logic [CNT_W-1:0] lim_scan;
		logic [CNT_W-1:0] lim_meas;
		logic [CNT_W-1:0] interval;
		logic [CNT_W-1:0] settle;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic abort_pend;
		logic aw_ok;
		logic [AXI_AW-1:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic meas_go;
		logic func_go;
		logic open_go;
		logic close_go;
		logic front_panel_fire_key_out;
	} lts_regs_t;

	localparam lts_regs_t REGS_RST = '{
		st: ST_ARM, ctrl: CTRL_RST, src_arm: SRC_IMM, src_scan: SRC_IMM, src_front_panel_fire_key: SRC_IMM,
		lim_arm: ARM_CNT_RST, lim_scan: SCAN_CNT_RST, lim_meas: CNT_INFINITE,
		interval: TIMER_RST, settle: SETTLE_RST, default: '0};

	lts_regs_t s_q, s_d;
	logic [2:0] pin_rise;
	logic ext_rise, link_rise, key_rise;
	logic scan_due, front_panel_fire_key_due;
	logic scan_restart, scan_consume, front_panel_fire_key_restart, front_panel_fire_key_consume;
	logic aw_take, w_take, do_wr, cmd_init, cmd_trg, cmd_abort, abort_go;
	logic adv, cont, hit_arm, hit_scan, hit_front_panel_fire_key;
	lts_src_t ea, es, et;
	logic [AXI_AW-1:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	lts_state_t nxt, act_first;
	logic [CNT_W-1:0] meas_n, scan_n, arm_n;

	function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// unoffered choices fall back to immediate rather than stalling forever
	function automatic lts_src_t eff_src(input lts_src_t s, input logic adv_m, input logic arm_l);
		eff_src = s;
		if (!adv_m && (s == SRC_LINK || s == SRC_HOLD)) eff_src = SRC_IMM;
		if (arm_l && s == SRC_TIMER) eff_src = SRC_IMM;
	endfunction : eff_src

	function automatic logic src_hit(input lts_src_t s, input logic bus_ev, input logic tmr);
		unique case (s)
			SRC_IMM: src_hit = 1'b1;
			SRC_EXT: src_hit = ext_rise;
			SRC_MAN: src_hit = key_rise;
			SRC_BUS: src_hit = bus_ev;
			SRC_LINK: src_hit = link_rise;
			SRC_TIMER: src_hit = tmr;
			default: src_hit = 1'b0;
		endcase
	endfunction : src_hit

	function automatic logic cnt_done(input logic [CNT_W-1:0] n, input logic [CNT_W-1:0] lim);
		cnt_done = (lim != CNT_INFINITE) && (n == lim);
	endfunction : cnt_done

	lts_pin_sync #(.W(3)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({front_panel_fire_key, daisy_chain_trigger_source, external_trigger_input}),
		.rise(pin_rise)
	);
	assign ext_rise = pin_rise[0];
	assign link_rise = pin_rise[1];
	assign key_rise = pin_rise[2];

	lts_interval_timer u_scan_tmr (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(s_q.tick),
		.restart(scan_restart),
		.consume(scan_consume),
		.interval(s_q.interval),
		.due(scan_due)
	);

	lts_interval_timer u_front_panel_fire_key_tmr (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(s_q.tick),
		.restart(front_panel_fire_key_restart),
		.consume(front_panel_fire_key_consume),
		.interval(s_q.interval),
		.due(front_panel_fire_key_due)
	);

	assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_ok && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;

	always_comb begin
		s_d = s_q;
		// timer base tick
		s_d.tick = 1'b0;
		if (s_q.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
			s_d.tick_cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 1'b1;
		end
		// register writes: address and data taken in either order
		aw_take = s_axi_awvalid && s_axi_awready;
		w_take = s_axi_wvalid && s_axi_wready;
		if (aw_take) begin
			s_d.aw_ok = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			s_d.w_ok = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		wa = s_q.aw_ok ? s_q.aw_addr : s_axi_awaddr;
		wd = s_q.w_ok ? s_q.w_data : s_axi_wdata;
		ws = s_q.w_ok ? s_q.w_strb : s_axi_wstrb;
		do_wr = (s_q.aw_ok || aw_take) && (s_q.w_ok || w_take);
		cmd_init = 1'b0;
		cmd_trg = 1'b0;
		cmd_abort = 1'b0;
		if (do_wr) begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			unique case (wa)
				REG_CTRL: if (ws[0]) s_d.ctrl = wd[CTRL_W-1:0];
				REG_CMD: if (ws[0]) begin
					cmd_init = wd[CMD_INIT];
					cmd_trg = wd[CMD_TRG];
					cmd_abort = wd[CMD_ABORT];
				end
				REG_SRC: begin
					if (ws[0]) begin
						s_d.src_arm = wd[SRC_ARM_LSB +: 3];
						s_d.src_scan = wd[SRC_SCAN_LSB +: 3];
					end
					if (ws[1]) s_d.src_front_panel_fire_key = wd[SRC_FRONT_PANEL_FIRE_KEY_LSB +: 3];
				end
				REG_ARM_CNT: s_d.lim_arm = merge16(s_q.lim_arm, wd, ws);
				REG_SCAN_CNT: s_d.lim_scan = merge16(s_q.lim_scan, wd, ws);
				REG_MEAS_CNT: s_d.lim_meas = merge16(s_q.lim_meas, wd, ws);
				REG_TIMER: s_d.interval = merge16(s_q.interval, wd, ws);
				REG_SETTLE: s_d.settle = merge16(s_q.settle, wd, ws);
				REG_STATUS: ;
				default: s_d.bresp = RESP_DECERR;
			endcase
		end else if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// register reads
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL: s_d.rdata = 32'(s_q.ctrl);
				REG_SRC: s_d.rdata = 32'({s_q.src_front_panel_fire_key, 1'b0, s_q.src_scan, 1'b0, s_q.src_arm});
				REG_ARM_CNT: s_d.rdata = 32'(s_q.lim_arm);
				REG_SCAN_CNT: s_d.rdata = 32'(s_q.lim_scan);
				REG_MEAS_CNT: s_d.rdata = 32'(s_q.lim_meas);
				REG_TIMER: s_d.rdata = 32'(s_q.interval);
				REG_SETTLE: s_d.rdata = 32'(s_q.settle);
				REG_STATUS: s_d.rdata = {s_q.meas_cnt, 8'(s_q.chan), 3'h0,
					s_q.st != ST_IDLE, 4'(s_q.st)};
				REG_CMD: s_d.rdata = '0;
				default: begin
					s_d.rdata = '0;
					s_d.rresp = RESP_DECERR;
				end
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// sequencer
		adv = s_q.ctrl[CTRL_ADV];
		cont = s_q.ctrl[CTRL_CONT];
		ea = eff_src(s_q.src_arm, adv, 1'b1);
		es = eff_src(s_q.src_scan, adv, 1'b0);
		et = eff_src(s_q.src_front_panel_fire_key, adv, 1'b0);
		hit_arm = src_hit(ea, bus_group_trigger || cmd_trg, 1'b0);
		hit_scan = src_hit(es, bus_group_trigger || cmd_trg, scan_due);
		hit_front_panel_fire_key = src_hit(et, bus_group_trigger || cmd_trg, front_panel_fire_key_due);
		act_first = s_q.ctrl[CTRL_FUNC] ? ST_FUNC :
			(s_q.ctrl[CTRL_SCAN] && s_q.ctrl[CTRL_INT]) ? ST_OPEN : ST_MEAS;
		meas_n = s_q.meas_cnt + 1'b1;
		scan_n = s_q.scan_cnt + 1'b1;
		arm_n = s_q.arm_cnt + 1'b1;
		// abort waits out a running output pulse so it is never cut short
		abort_go = (s_q.abort_pend || cmd_abort) && s_q.st != ST_OUT;
		s_d.abort_pend = (s_q.abort_pend || cmd_abort) && !abort_go;
		nxt = s_q.st;
		if (abort_go) begin
			nxt = ST_IDLE;
			s_d.arm_cnt = '0;
			s_d.scan_cnt = '0;
			s_d.meas_cnt = '0;
		end else begin
			unique case (s_q.st)
				ST_IDLE: if (cmd_init || key_rise) begin
					nxt = adv ? ST_ARM : (cont ? act_first : ST_FRONT_PANEL_FIRE_KEY);
				end
				ST_ARM: if (hit_arm) nxt = ST_SCAN;
				ST_SCAN: if (hit_scan) nxt = ST_FRONT_PANEL_FIRE_KEY;
				ST_FRONT_PANEL_FIRE_KEY: begin
					if (!adv && cont) begin
						nxt = act_first;
					end else if (hit_front_panel_fire_key) begin
						nxt = act_first;
					end
				end
				ST_FUNC: nxt = (s_q.ctrl[CTRL_SCAN] && s_q.ctrl[CTRL_INT]) ? ST_OPEN : ST_MEAS;
				ST_OPEN: begin
					nxt = ST_CLOSE;
					s_d.chan = (s_q.chan == CHAN_W'(CHAN_COUNT - 1)) ? '0 : s_q.chan + 1'b1;
				end
				ST_CLOSE: nxt = ST_SETTLE;
				ST_SETTLE: begin
					if (s_q.dly >= s_q.settle) begin
						nxt = ST_MEAS;
					end else begin
						s_d.dly = s_q.dly + 1'b1;
					end
				end
				ST_MEAS: if (meas_done) nxt = ST_OUT;
				ST_OUT: begin
					if (s_q.dly != CNT_W'(OUT_CYC - 1)) begin
						s_d.dly = s_q.dly + 1'b1;
					end else if (!adv) begin
						nxt = cont ? act_first : ST_FRONT_PANEL_FIRE_KEY;
					end else if (!cnt_done(meas_n, s_q.lim_meas)) begin
						s_d.meas_cnt = meas_n;
						nxt = ST_FRONT_PANEL_FIRE_KEY;
					end else begin
						s_d.meas_cnt = '0;
						if (!cnt_done(scan_n, s_q.lim_scan)) begin
							s_d.scan_cnt = scan_n;
							nxt = ST_SCAN;
						end else begin
							s_d.scan_cnt = '0;
							if (!cnt_done(arm_n, s_q.lim_arm)) begin
								s_d.arm_cnt = arm_n;
								nxt = ST_ARM;
							end else begin
								s_d.arm_cnt = '0;
								nxt = ST_IDLE;
							end
						end
					end
				end
				default: nxt = ST_IDLE;
			endcase
		end
		if (nxt != s_q.st) s_d.dly = '0;
		s_d.st = nxt;
		s_d.meas_go = (nxt == ST_MEAS) && (s_q.st != ST_MEAS);
		s_d.func_go = nxt == ST_FUNC;
		s_d.open_go = nxt == ST_OPEN;
		s_d.close_go = nxt == ST_CLOSE;
		s_d.front_panel_fire_key_out = nxt == ST_OUT;
		// timer first pass restarts whenever its layer is entered from above
		scan_restart = (s_q.st == ST_IDLE) || (s_q.st == ST_ARM && hit_arm);
		scan_consume = (s_q.st == ST_SCAN) && hit_scan && !abort_go;
		front_panel_fire_key_restart = (s_q.st == ST_IDLE) || (s_q.st == ST_SCAN && hit_scan);
		front_panel_fire_key_consume = (s_q.st == ST_FRONT_PANEL_FIRE_KEY) && hit_front_panel_fire_key && !abort_go;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= REGS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign seq_active = s_q.st != ST_IDLE;
	assign meas_start = s_q.meas_go;
	assign func_change = s_q.func_go;
	assign relay_open = s_q.open_go;
	assign relay_close = s_q.close_go;
	assign relay_channel = s_q.chan;
	assign output_trigger = s_q.front_panel_fire_key_out;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	start_exit_a: assert property (s_q.st == ST_IDLE && (cmd_init || key_rise) && !abort_go
		|=> seq_active) else $error("start did not leave idle");
	imm_pass_a: assert property (s_q.st == ST_FRONT_PANEL_FIRE_KEY && et == SRC_IMM && !abort_go
		|=> s_q.st != ST_FRONT_PANEL_FIRE_KEY) else $error("immediate source stalled");
	hold_pause_a: assert property (s_q.st == ST_FRONT_PANEL_FIRE_KEY && et == SRC_HOLD && !abort_go
		|=> s_q.st == ST_FRONT_PANEL_FIRE_KEY) else $error("hold released");
	basic_link_a: assert property (s_q.st == ST_FRONT_PANEL_FIRE_KEY && !adv && s_q.src_front_panel_fire_key == SRC_LINK
		&& !abort_go |=> s_q.st != ST_FRONT_PANEL_FIRE_KEY) else $error("link offered in basic");
	arm_timer_a: assert property (s_q.st == ST_ARM && s_q.src_arm == SRC_TIMER && !abort_go
		|=> s_q.st == ST_SCAN) else $error("timer offered in arm layer");
	cont_skip_a: assert property (s_q.st == ST_FRONT_PANEL_FIRE_KEY && !adv && cont && !abort_go
		|=> s_q.st != ST_FRONT_PANEL_FIRE_KEY) else $error("continuous basic waited");
	out_width_a: assert property ($rose(output_trigger)
		|-> ##99 output_trigger ##1 !output_trigger) else $error("output pulse width");
	out_cause_a: assert property ($rose(output_trigger)
		|-> $past(s_q.st) == ST_MEAS && $past(meas_done)) else $error("pulse without measurement");
	bbm_order_a: assert property (relay_close && !abort_go |-> $past(relay_open) ##1
		s_q.st == ST_SETTLE) else $error("break before make broken");
	scan_meas_a: assert property (meas_start && s_q.ctrl[CTRL_SCAN] && s_q.ctrl[CTRL_INT]
		|-> $past(s_q.st) == ST_SETTLE) else $error("measured before channel closed");
	idle_clear_a: assert property (s_q.st == ST_IDLE
		|-> s_q.arm_cnt == '0 && s_q.scan_cnt == '0 && s_q.meas_cnt == '0)
		else $error("counter not cleared at idle");

	done_idle_c: cover property (s_q.st == ST_OUT && s_d.st == ST_IDLE);
	scan_act_c: cover property (relay_open ##1 relay_close ##[1:200] meas_start);
	basic_run_c: cover property (!adv && !cont && output_trigger);
	hold_c: cover property (s_q.st == ST_FRONT_PANEL_FIRE_KEY && et == SRC_HOLD [*4]);
endmodule : lts_sequencer
`default_nettype wire

// >>> test/lts_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module lts_far_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic meas_start,
	input wire logic output_trigger,
	input wire logic [7:0] dly,
	output logic meas_done,
	output int chan_seen
);
	logic busy;
	logic [7:0] cnt;
	logic ot_q;
	// measuring engine: done pulse dly+1 cycles after the cycle it samples start; no early answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			meas_done <= 1'b0;
			ot_q <= 1'b0;
			chan_seen <= 0;
		end else begin
			meas_done <= 1'b0;
			ot_q <= output_trigger;
			if (meas_start) begin
				busy <= 1'b1;
				cnt <= dly;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'b0;
				meas_done <= 1'b1;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
			if (output_trigger && !ot_q) begin
				chan_seen <= chan_seen + 1;
			end
		end
	end
endmodule : lts_far_model
`default_nettype wire

// >>> test/layered_trigger_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module layered_trigger_sequencer_bench import lts_pkg::*;;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, dly = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, bus_group_trigger = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic [2:0] pins = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic meas_done, seq_active, meas_start, func_change, relay_open, relay_close;
	wire logic output_trigger;
	wire logic [3:0] relay_channel;
	int chan_seen, error_cnt = 0, n_checks = 0, n_meas = 0, n_close = 0, n_func = 0;
	int cyc = 0, close_cyc = 0, wid = 0, base, cnt, i;
	logic po = 0, scan_on = 0;
	logic [3:0] last_ch = 0;
	logic [33:0] exp_q[$];
	logic [1:0] bq[$];
	lts_src_t codes[5] = '{SRC_EXT, SRC_LINK, SRC_MAN, SRC_BUS, SRC_BUS};

	always #50 aclk = ~aclk;

	lts_sequencer #(.CHAN_COUNT(10), .CHAN_W(4)) u_dut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .external_trigger_input(pins[0]),
		.daisy_chain_trigger_source(pins[1]), .front_panel_fire_key(pins[2]),
		.bus_group_trigger, .meas_done, .seq_active, .meas_start, .func_change,
		.relay_open, .relay_close, .relay_channel, .output_trigger);
	lts_far_model u_far (.aclk, .aresetn, .meas_start, .output_trigger, .dly,
		.meas_done, .chan_seen);

	// monitor: settled pre-edge values are what the edge sampled
	always @(posedge aclk) begin
		cyc++;
		if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
			`CHK({s_axi_rresp, s_axi_rdata}, exp_q.pop_front())
		end
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
			`CHK(s_axi_bresp, bq.pop_front())
		end
		if (po) begin
			`CHK(relay_close, 1'b1)
		end
		po = relay_open;
		if (relay_close) begin
			`CHK(relay_channel, last_ch + 4'h1)
			last_ch = relay_channel;
			close_cyc = cyc;
			n_close++;
		end
		if (meas_start) begin
			n_meas++;
			if (scan_on) begin
				`CHK(cyc - close_cyc >= 4, 1'b1)
			end
		end
		if (func_change) n_func++;
		if (output_trigger) wid++;
		else if (wid != 0) begin
			`CHK(wid, OUT_CYC)
			wid = 0;
		end
	end

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic timeout(input int lim);
		error_cnt++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 0, lim);
		summarize();
	endtask : timeout

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		bq.push_back(er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 0;
				return;
			end
		end
		timeout(k);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		exp_q.push_back({er, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 0;
				return;
			end
		end
		timeout(k);
	endtask : rd

	task automatic wait_idle(input int lim);
		int k;
		for (k = 0; k < lim; k++) begin
			@(posedge aclk);
			if (!seq_active) return;
		end
		timeout(k);
	endtask : wait_idle

	task automatic wait_meas(input int lim);
		int k;
		int b;
		b = n_meas;
		for (k = 0; k < lim; k++) begin
			@(posedge aclk);
			if (n_meas != b) return;
		end
		timeout(k);
	endtask : wait_meas

	// pins are synchronised, so hold each pulse a few cycles
	task automatic fire(input int k);
		@(posedge aclk);
		if (k < 3) pins[k] <= 1'b1;
		else if (k == 3) bus_group_trigger <= 1'b1;
		@(posedge aclk);
		bus_group_trigger <= 1'b0;
		repeat (2) @(posedge aclk);
		pins <= 3'h0;
		if (k == 4) wr(REG_CMD, 32'h2, RESP_OKAY);
	endtask : fire

	task automatic stop();
		wr(REG_CMD, 32'h4, RESP_OKAY);
		wait_idle(400);
	endtask : stop

	initial begin
		void'($urandom(23));
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		dly <= 8'($urandom % 8);
		wait_meas(50);
		`CHK(seq_active, 1'b1)
		rd(REG_CTRL, {27'h0, CTRL_RST}, RESP_OKAY);
		rd(REG_SRC, 32'h0, RESP_OKAY);
		rd(REG_MEAS_CNT, 32'h0, RESP_OKAY);
		wait_meas(200);
		rd(8'hfc, 32'h0, RESP_DECERR);
		wr(8'hfc, 32'h5, RESP_DECERR);
		stop();
		rd(REG_STATUS, 32'h0, RESP_OKAY);
		$display("test defaults done");
		fire(2);
		wait_meas(50);
		`CHK(seq_active, 1'b1)
		stop();
		$display("test start key done");
		cnt = 1 + $urandom % 4;
		dly <= 8'($urandom % 8);
		wr(REG_ARM_CNT, 32'h2, RESP_OKAY);
		wr(REG_MEAS_CNT, 32'(cnt), RESP_OKAY);
		base = chan_seen;
		wr(REG_CMD, 32'h1, RESP_OKAY);
		wait_idle(2000);
		`CHK(chan_seen - base, 2 * cnt)
		wr(REG_ARM_CNT, 32'h1, RESP_OKAY);
		wr(REG_MEAS_CNT, 32'h1, RESP_OKAY);
		$display("test counters done");
		for (i = 0; i < 5; i++) begin
			wr(REG_SRC, {21'h0, codes[i], 8'h00}, RESP_OKAY);
			base = n_meas;
			wr(REG_CMD, 32'h1, RESP_OKAY);
			repeat (30) @(posedge aclk);
			`CHK(n_meas - base, 0)
			fire(i);
			wait_idle(500);
			`CHK(n_meas - base, 1)
		end
		$display("test sources done");
		wr(REG_SRC, {21'h0, SRC_HOLD, 8'h00}, RESP_OKAY);
		base = n_meas;
		wr(REG_CMD, 32'h1, RESP_OKAY);
		fire(0);
		repeat (200) @(posedge aclk);
		`CHK(n_meas - base, 0)
		stop();
		$display("test hold done");
		wr(REG_TIMER, 32'h2, RESP_OKAY);
		wr(REG_MEAS_CNT, 32'h2, RESP_OKAY);
		wr(REG_SRC, {21'h0, SRC_TIMER, 8'h05}, RESP_OKAY);
		wr(REG_CMD, 32'h1, RESP_OKAY);
		wait_meas(30);
		base = cyc;
		wait_meas(3000);
		`CHK(cyc - base >= TICK_CYC, 1'b1)
		wait_idle(500);
		$display("test timer done");
		wr(REG_SRC, {21'h0, SRC_EXT, 8'h00}, RESP_OKAY);
		wr(REG_CTRL, 32'h2, RESP_OKAY);
		base = n_meas;
		wr(REG_CMD, 32'h1, RESP_OKAY);
		repeat (200) @(posedge aclk);
		`CHK(n_meas - base > 1, 1'b1)
		stop();
		wr(REG_CTRL, 32'h0, RESP_OKAY);
		wr(REG_SRC, {21'h0, SRC_LINK, 8'h00}, RESP_OKAY);
		base = n_meas;
		wr(REG_CMD, 32'h1, RESP_OKAY);
		wait_meas(50);
		`CHK(n_meas - base > 0, 1'b1)
		stop();
		$display("test continuous done");
		wr(REG_SRC, 32'h0, RESP_OKAY);
		wr(REG_SETTLE, 32'h3, RESP_OKAY);
		wr(REG_CTRL, 32'h1d, RESP_OKAY);
		base = n_close;
		cnt = n_func;
		scan_on = 1;
		wr(REG_CMD, 32'h1, RESP_OKAY);
		wait_idle(2000);
		scan_on = 0;
		`CHK(n_close - base, 2)
		`CHK(n_func - cnt, 2)
		$display("test scan done");
		summarize();
	end
endmodule : layered_trigger_sequencer_bench
`default_nettype wire
